// [address_breakpoint_unit.sv]
// Operation
// - With break enable set, full 16-bit address match raises a break.
// - Watchdog hold bit suspends the watchdog during a break interrupt.
// - Watchdog suspension applies only in a break while monitor mode is set.
// - Flag clear enable set: writing one to a status flag during break clears it.
// - Flag clear enable clear: status accesses during break leave flags.
`timescale 1ns/1ns
module address_breakpoint_unit
    import break_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [15:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire cpu_bus_s    CPU_BUS,
    input  wire logic        MONITOR_MODE,
    input  wire logic        EMU_STATUS_IN,
    output logic             BREAK_REQ,
    output logic             WATCHDOG_HOLD,
    output logic             FLAG_CLEAR_OK,
    output logic             IRQ
);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_DONE   = 3'b100
    } apb_st_e;

    apb_st_e     st_q;
    apb_st_e     st_d;
    logic        brk_en_q;
    logic        brk_act_q;
    logic        wdog_hold_q;
    logic        clr_en_q;
    logic        emu_stat_q;
    logic [7:0]  addr_hi_q;
    logic [7:0]  addr_lo_q;
    logic [1:0]  ev_stat_q;
    logic [1:0]  ev_mask_q;
    logic        match;
    logic        wr_now;
    logic        rd_now;
    logic        forced;
    logic [1:0]  ev_set;
    logic [31:0] rd_data;
    logic        mapped;

    // Register decode for the error answer; the read mux decodes on its own
    function automatic logic is_mapped(input logic [15:0] a);
        logic hit;
        case (a)
            OFS_EMU_STATUS: hit = 1'b1;
            OFS_AUX_CTRL:   hit = 1'b1;
            OFS_FLAG_CTRL:  hit = 1'b1;
            OFS_ADDR_HIGH:  hit = 1'b1;
            OFS_ADDR_LOW:   hit = 1'b1;
            OFS_STAT_CTRL:  hit = 1'b1;
            OFS_IRQ_STATUS: hit = 1'b1;
            OFS_IRQ_MASK:   hit = 1'b1;
            default:        hit = 1'b0; // Holes answer with an error
        endcase
        return hit;
    endfunction : is_mapped

    // Access phase takes one wait state so read data comes from a flop
    always_comb begin
        case (st_q)
            ST_IDLE: begin
                if (PSEL && !PENABLE) begin
                    st_d = ST_ACCESS;
                end else begin
                    st_d = ST_IDLE;
                end
            end
            ST_ACCESS: begin
                st_d = ST_DONE;
            end
            ST_DONE: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Write and read take effect on the edge where PREADY is seen high
    assign wr_now = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_now = PSEL && PENABLE && PREADY && !PWRITE;
    assign mapped = is_mapped(PADDR);

    // Full 16-bit compare only while breaks are enabled
    assign match = brk_en_q && CPU_BUS.valid
        && (CPU_BUS.addr == {addr_hi_q, addr_lo_q});
    assign forced = wr_now && (PADDR == OFS_STAT_CTRL)
        && PWDATA[BIT_BRK_ACTIVE] && !brk_act_q;
    assign ev_set = {forced, match && !brk_act_q};

    // Break enable bit
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            brk_en_q <= 1'b0;
        end else if (wr_now && PADDR == OFS_STAT_CTRL) begin
            brk_en_q <= PWDATA[BIT_BRK_ENABLE];
        end
    end

    // Break address, high byte
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            addr_hi_q <= RST_BYTE;
        end else if (wr_now && PADDR == OFS_ADDR_HIGH) begin
            addr_hi_q <= PWDATA[7:0];
        end
    end

    // Break address, low byte; halves written apart, so set enable last
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            addr_lo_q <= RST_BYTE;
        end else if (wr_now && PADDR == OFS_ADDR_LOW) begin
            addr_lo_q <= PWDATA[7:0];
        end
    end

    // Break active: match sets, write of one forces, write of zero clears
    // A match in the clearing cycle wins so no break is lost
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            brk_act_q <= 1'b0;
        end else if (match) begin
            brk_act_q <= 1'b1;
        end else if (wr_now && PADDR == OFS_STAT_CTRL) begin
            brk_act_q <= PWDATA[BIT_BRK_ACTIVE];
        end
    end

    // Auxiliary control: watchdog hold request
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wdog_hold_q <= 1'b0;
        end else if (wr_now && PADDR == OFS_AUX_CTRL) begin
            wdog_hold_q <= PWDATA[BIT_WDOG_HOLD];
        end
    end

    // Flag-clear control: lets a debugger clear flags in a break
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            clr_en_q <= 1'b0;
        end else if (wr_now && PADDR == OFS_FLAG_CTRL) begin
            clr_en_q <= PWDATA[BIT_CLR_ENABLE];
        end
    end

    // Emulator status is owned by the emulator pin, not software
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            emu_stat_q <= 1'b0;
        end else begin
            emu_stat_q <= EMU_STATUS_IN;
        end
    end

    // Sticky event flags, write one to clear; a new event wins.
    // During a break the clear is honoured only with flag clear enable.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ev_stat_q <= RST_EV;
        end else if (wr_now && PADDR == OFS_IRQ_STATUS
                     && (!brk_act_q || clr_en_q)) begin
            ev_stat_q <= (ev_stat_q & ~PWDATA[1:0]) | ev_set;
        end else begin
            ev_stat_q <= ev_stat_q | ev_set;
        end
    end

    // Interrupt mask, same layout as the event flags
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ev_mask_q <= RST_EV;
        end else if (wr_now && PADDR == OFS_IRQ_MASK) begin
            ev_mask_q <= PWDATA[1:0];
        end
    end

    // Read mux; reserved bits read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (PADDR)
            OFS_EMU_STATUS: begin
                rd_data[BIT_EMU_STATUS] = emu_stat_q;
            end
            OFS_AUX_CTRL: begin
                rd_data[BIT_WDOG_HOLD] = wdog_hold_q;
            end
            OFS_FLAG_CTRL: begin
                rd_data[BIT_CLR_ENABLE] = clr_en_q;
            end
            OFS_ADDR_HIGH: begin
                rd_data[7:0] = addr_hi_q;
            end
            OFS_ADDR_LOW: begin
                rd_data[7:0] = addr_lo_q;
            end
            OFS_STAT_CTRL: begin
                rd_data[BIT_BRK_ENABLE] = brk_en_q;
                rd_data[BIT_BRK_ACTIVE] = brk_act_q;
            end
            OFS_IRQ_STATUS: begin
                rd_data[1:0] = ev_stat_q;
            end
            OFS_IRQ_MASK: begin
                rd_data[1:0] = ev_mask_q;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Ready pulse in the second access cycle, from a flop
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= (st_d == ST_DONE);
        end
    end

    // Error answer for holes in the map
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= (st_d == ST_DONE) && !mapped;
        end
    end

    // Read data only beside the ready pulse, zero otherwise
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (st_d == ST_DONE) begin
            PRDATA <= rd_data;
        end else begin
            PRDATA <= 32'h0000_0000;
        end
    end

    // Break request to the CPU, one cycle behind the active bit
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            BREAK_REQ <= 1'b0;
        end else begin
            BREAK_REQ <= brk_act_q;
        end
    end

    // Watchdog hold needs break and monitor mode together
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WATCHDOG_HOLD <= 1'b0;
        end else begin
            WATCHDOG_HOLD <= wdog_hold_q && brk_act_q
                             && MONITOR_MODE;
        end
    end

    // Clearing allowed outside a break, or with the enable set
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FLAG_CLEAR_OK <= 1'b0;
        end else begin
            FLAG_CLEAR_OK <= !brk_act_q || clr_en_q;
        end
    end

    // Level interrupt while any unmasked flag stands
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(ev_stat_q & ev_mask_q);
        end
    end

    // Read strobe kept for clarity of bus timing; no read side effects
    logic unused_rd;
    assign unused_rd = rd_now;

endmodule : address_breakpoint_unit

// [break_pkg.sv]
package break_pkg;

    // Register byte offsets within the APB window
    localparam logic [15:0] OFS_EMU_STATUS  = 16'hfe00;
    localparam logic [15:0] OFS_AUX_CTRL    = 16'hfe02;
    localparam logic [15:0] OFS_FLAG_CTRL   = 16'hfe03;
    localparam logic [15:0] OFS_ADDR_HIGH   = 16'hfe09;
    localparam logic [15:0] OFS_ADDR_LOW    = 16'hfe0a;
    localparam logic [15:0] OFS_STAT_CTRL   = 16'hfe0b;
    localparam logic [15:0] OFS_IRQ_STATUS  = 16'hfe10;
    localparam logic [15:0] OFS_IRQ_MASK    = 16'hfe14;

    // Field positions
    localparam int BIT_BRK_ENABLE   = 7;
    localparam int BIT_BRK_ACTIVE   = 6;
    localparam int BIT_WDOG_HOLD    = 0;
    localparam int BIT_CLR_ENABLE   = 6;
    localparam int BIT_EMU_STATUS   = 1;
    localparam int BIT_EV_MATCH     = 0;
    localparam int BIT_EV_FORCED    = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_EV   = 2'h0;

    // CPU bus view seen by the comparator
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } cpu_bus_s;

endpackage : break_pkg

// [address_breakpoint_unit_assertions.sv]
`timescale 1ns/1ns
module address_breakpoint_unit_assertions
    import break_pkg::*;
(
    input wire logic     CLK,
    input wire logic     RST_N,
    input wire logic     PSEL,
    input wire logic     PENABLE,
    input wire logic     PWRITE,
    input wire logic     PREADY,
    input wire logic     PSLVERR,
    input wire cpu_bus_s CPU_BUS,
    input wire logic     MONITOR_MODE,
    input wire logic     BREAK_REQ,
    input wire logic     WATCHDOG_HOLD,
    input wire logic     FLAG_CLEAR_OK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Only a fetch or a register write may start a break
    wire logic cause = CPU_BUS.valid || (PREADY && PWRITE);
    sequence ready_after_setup;
        !PREADY ##1 PREADY;
    endsequence
    a_ready_two_cycles: assert property (PSEL && !PENABLE |=> ready_after_setup)
        else $error("ready not two cycles after setup");
    a_ready_one_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_break_has_cause: assert property ($rose(BREAK_REQ) |->
        $past(cause, 2) || $past(cause, 3)) else $error("break without cause");
    a_hold_in_break: assert property (WATCHDOG_HOLD |-> BREAK_REQ)
        else $error("watchdog hold outside break");
    a_hold_needs_monitor: assert property (WATCHDOG_HOLD |-> $past(MONITOR_MODE))
        else $error("watchdog hold without monitor mode");
    a_clear_outside_break: assert property ($past(RST_N) && !BREAK_REQ |->
        FLAG_CLEAR_OK) else $error("flag clear blocked outside break");
endmodule : address_breakpoint_unit_assertions

// [cpu_bus_model.sv]
`timescale 1ns/1ns
module cpu_bus_model
    import break_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        fetch,
    input  wire logic [15:0] addr,
    output cpu_bus_s         bus
);
    // Idle address keeps toggling, so a stale value never matches by luck
    initial bus = '0;
    always @(posedge CLK) begin
        bus.valid <= fetch;
        bus.addr  <= fetch ? addr : ~bus.addr;
    end
endmodule : cpu_bus_model

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top import break_pkg::*;;
    logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [15:0] PADDR = '0, cpu_addr = '0, brk;
    logic [31:0] PWDATA = '0, PRDATA;
    logic        PREADY, PSLVERR, MONITOR_MODE = 0, EMU_STATUS_IN = 0;
    logic        BREAK_REQ, WATCHDOG_HOLD, FLAG_CLEAR_OK, IRQ, cpu_fetch = 0;
    cpu_bus_s    CPU_BUS;
    logic [32:0] exp_q[$], exp;
    int          failures = 0, num_checks = 0, seed = 67;
    logic [15:0] regs[8] = '{OFS_EMU_STATUS, OFS_AUX_CTRL, OFS_FLAG_CTRL,
        OFS_ADDR_HIGH, OFS_ADDR_LOW, OFS_STAT_CTRL, OFS_IRQ_STATUS, OFS_IRQ_MASK};
    address_breakpoint_unit address_breakpoint_unit_i (.*);
    cpu_bus_model cpu_bus_model_i (.CLK(CLK), .fetch(cpu_fetch),
        .addr(cpu_addr), .bus(CPU_BUS));
    always #20 CLK = ~CLK;
    task chk(input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    // One APB transfer; a read notes its answer, then things settle
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
              input logic [32:0] e);
        if (!w) exp_q.push_back(e);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask : xfer
    task fetch(input logic [15:0] a);
        cpu_fetch <= 1'b1;
        cpu_addr  <= a;
        @(posedge CLK);
        cpu_fetch <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask : fetch
    task test_done;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Each read answer meets the oldest note
    always @(posedge CLK) begin
        if (PREADY === 1'b1 && PWRITE === 1'b0) begin
            exp = exp_q.pop_front();
            chk({PSLVERR, PRDATA}, exp);
        end
    end
    // Cuts a hang short
    initial begin
        repeat (3000) @(posedge CLK);
        failures++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        foreach (regs[i]) xfer(0, regs[i], 0, 33'h0);
        xfer(0, 16'hfe04, 0, 33'h100000000);
        EMU_STATUS_IN <= 1'b1;
        xfer(0, OFS_EMU_STATUS, 0, 33'h2);
        $display("test reset done");
        brk = 16'($random(seed));
        xfer(1, OFS_ADDR_HIGH, {24'h0, brk[15:8]}, 0);
        xfer(1, OFS_ADDR_LOW, {24'h0, brk[7:0]}, 0);
        xfer(1, OFS_IRQ_MASK, 32'h3, 0);
        fetch(brk);
        chk(BREAK_REQ, 0);
        xfer(1, OFS_STAT_CTRL, 32'h80, 0);
        fetch(brk ^ 16'h8000);
        chk(BREAK_REQ, 0);
        fetch(brk);
        chk(BREAK_REQ, 1);
        chk(IRQ, 1);
        xfer(0, OFS_STAT_CTRL, 0, 33'hc0);
        $display("test match done");
        // Status clear refused in break until the enable is set
        xfer(1, OFS_IRQ_STATUS, 32'h1, 0);
        xfer(0, OFS_IRQ_STATUS, 0, 33'h1);
        chk(FLAG_CLEAR_OK, 0);
        xfer(1, OFS_AUX_CTRL, 32'h1, 0);
        chk(WATCHDOG_HOLD, 0);
        MONITOR_MODE <= 1'b1;
        repeat (4) @(posedge CLK);
        chk(WATCHDOG_HOLD, 1);
        xfer(1, OFS_FLAG_CTRL, 32'h40, 0);
        chk(FLAG_CLEAR_OK, 1);
        xfer(1, OFS_IRQ_STATUS, 32'h1, 0);
        xfer(0, OFS_IRQ_STATUS, 0, 33'h0);
        chk(IRQ, 0);
        $display("test flags done");
        xfer(1, OFS_STAT_CTRL, 32'h80, 0);
        chk(BREAK_REQ, 0);
        chk(WATCHDOG_HOLD, 0);
        xfer(1, OFS_STAT_CTRL, 32'h40, 0);
        chk(BREAK_REQ, 1);
        xfer(0, OFS_IRQ_STATUS, 0, 33'h2);
        chk(IRQ, 1);
        $display("test forced done");
        test_done();
    end
endmodule : tb_top
bind address_breakpoint_unit address_breakpoint_unit_assertions chk_i (.*);
